// *** design/sfdr_core.sv ***
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
// ==================================================================
// Overview of operation
// R1: Dual-output fast read drives two data bits per clock on both lanes.
// R2: Eight dummy clocks follow the address; lane input then is ignored.
// R3: Host frees lane zero before the first data-out falling edge.
// R4: Dual I/O read takes its 24-bit address two bits per clock.
// R5: A read mode byte follows the dual address on both lanes.
// R6: Mode pair 10 makes the next transaction a dual read without opcode.
// R7: Any other mode pair restores opcode decoding on the next transaction.
// R8: Reserved mode bits are accepted with any value, no effect.
// R9: Sixteen all-ones clocks set mode bit four and leave persistent mode.
// R10: In persistent mode ordinary opcodes are not decoded.
// R11: Host should send the all-ones escape first after its reset.
// R12: Program needs the write latch; opcode, address, data with select low.
// R13: Program loads one to 256 bytes, untouched bytes stay as they were.
// R14: Program column wraps inside the page; surplus bytes overwrite.
// R15: Select rising off a byte boundary discards the program.
// R16: Self-timed program cycle holds busy high, then clears it.
// R17: Status reads are answered during a program cycle.
// R18: Write latch clears when the program cycle finishes.
// R19: Program to a protected page is refused.
// R20: Write enable opcode sets the write latch.
// R21: Dual byte split: lane one odd bits, lane zero even bits, MSB pair first.
// R22: Read address increments per byte; output streams while clocked.
// R23: Persistent read mode survives select high until cleared.
// R24: Reads issued while busy are ignored.
module sfdr_core #(
  parameter int PROG_TIME_NS = 700000,
  parameter int MEM_PAGES = 2
) (
  input logic SYS_CLK,
  input logic RST_B,
  input logic CS_B,
  input logic SCLK,
  input logic IO0_IN,
  output logic IO0_OUT,
  output logic IO0_OE_B,
  input logic IO1_IN,
  output logic IO1_OUT,
  output logic IO1_OE_B,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [sfdr_pkg::APB_AW-1:0] PADDR,
  input logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  localparam int PROG_CYC_RAW = (PROG_TIME_NS * sfdr_pkg::CLK_MHZ + sfdr_pkg::NS_PER_US - 1)
                                / sfdr_pkg::NS_PER_US;
  localparam int PROG_CYC = (PROG_CYC_RAW < 1) ? 1 : PROG_CYC_RAW;
  localparam int PG_W = (MEM_PAGES > 1) ? $clog2(MEM_PAGES) : 1;
  localparam int MEM_AW = PG_W + sfdr_pkg::PAGE_AW;
  localparam int MEM_BYTES = MEM_PAGES * sfdr_pkg::PAGE_BYTES;

  // ================================================================
  // Pin sampling and edges
  sfdr_pkg::sfdr_pins_t pin_raw;
  sfdr_pkg::sfdr_pins_t pin_q;
  logic sclk_d_r;
  logic cs_b_d_r;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign pin_raw = '{cs_b: CS_B, sclk: SCLK, io1: IO1_IN, io0: IO0_IN};

  sfdr_pin_sync u_sync (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .pins_in(pin_raw),
    .pins_out(pin_q)
  );

  assign cs_fall = cs_b_d_r & ~pin_q.cs_b;
  assign cs_rise = ~cs_b_d_r & pin_q.cs_b;
  assign sclk_rise = pin_q.sclk & ~sclk_d_r & ~pin_q.cs_b & ~cs_fall;
  assign sclk_fall = ~pin_q.sclk & sclk_d_r & ~pin_q.cs_b & ~cs_fall;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_d_r <= 1'b0;
      cs_b_d_r <= 1'b1;
    end else begin
      sclk_d_r <= pin_q.sclk;
      cs_b_d_r <= pin_q.cs_b;
    end
  end

  // ================================================================
  // Sequencer state and decode
  sfdr_pkg::sfdr_state_t st_r;
  sfdr_pkg::sfdr_state_t cmd_next;
  logic [4:0] cnt_r;
  logic [4:0] phase_last;
  logic phase_end;
  logic [7:0] sh_r;
  logic [7:0] cmd_r;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [sfdr_pkg::ADDR_W-1:0] addr_r;
  logic [sfdr_pkg::ADDR_W-1:0] addr1_nxt;
  logic [sfdr_pkg::ADDR_W-1:0] addr2_nxt;
  logic [7:0] col_r;
  logic ones_r;
  logic [7:0] mode_r;
  logic cont_mode;
  logic cmd_end;
  logic mode_end;
  logic esc_hit;
  logic wren_hit;
  logic pgm_byte;
  logic rd_load;
  logic busy_r;
  logic wel_r;
  logic [2:0] out_cnt_r;

  assign byte1 = {sh_r[6:0], pin_q.io0};
  assign byte2 = {sh_r[5:0], pin_q.io1, pin_q.io0};
  assign addr1_nxt = {addr_r[sfdr_pkg::ADDR_W-2:0], pin_q.io0};
  assign addr2_nxt = {addr_r[sfdr_pkg::ADDR_W-3:0], pin_q.io1, pin_q.io0};
  assign cont_mode = (mode_r[sfdr_pkg::MODE_BIT_FOUR+1:sfdr_pkg::MODE_BIT_FOUR]
                      == sfdr_pkg::MODE_KEEP);
  assign phase_last = (st_r == sfdr_pkg::ST_ADDR1) ? sfdr_pkg::ADDR1_LAST :
                      (st_r == sfdr_pkg::ST_ADDR2) ? sfdr_pkg::ADDR2_LAST :
                      (st_r == sfdr_pkg::ST_MODE) ? sfdr_pkg::MODE_LAST : sfdr_pkg::BYTE_LAST;
  assign phase_end = (cnt_r == phase_last);
  assign cmd_end = sclk_rise & (st_r == sfdr_pkg::ST_CMD) & phase_end;
  assign mode_end = sclk_rise & (st_r == sfdr_pkg::ST_MODE) & phase_end;
  assign esc_hit = mode_end & ones_r & pin_q.io0 & pin_q.io1;
  assign wren_hit = cmd_end & (byte1 == sfdr_pkg::OP_WREN) & ~busy_r;
  assign pgm_byte = sclk_rise & (st_r == sfdr_pkg::ST_PGM) & phase_end;
  assign rd_load = sclk_fall & (st_r == sfdr_pkg::ST_RDOUT) & (out_cnt_r == 3'h0);

  always_comb begin
    case (byte1)
      sfdr_pkg::OP_RD_DUAL_OUT: cmd_next = busy_r ? sfdr_pkg::ST_IDLE : sfdr_pkg::ST_ADDR1; // R24
      sfdr_pkg::OP_RD_DUAL_IO: cmd_next = busy_r ? sfdr_pkg::ST_IDLE : sfdr_pkg::ST_ADDR2; // R24
      sfdr_pkg::OP_PROG: cmd_next = (busy_r | ~wel_r) ? sfdr_pkg::ST_IDLE : sfdr_pkg::ST_ADDR1; // R12
      sfdr_pkg::OP_STATUS: cmd_next = sfdr_pkg::ST_STAT; // R17
      default: cmd_next = sfdr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= sfdr_pkg::ST_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      cmd_r <= sfdr_pkg::OP_NONE;
      addr_r <= '0;
      col_r <= '0;
      ones_r <= 1'b0;
    end else if (cs_fall) begin
      st_r <= cont_mode ? sfdr_pkg::ST_ADDR2 : sfdr_pkg::ST_CMD; // R6 R10 R23
      cmd_r <= cont_mode ? sfdr_pkg::OP_RD_DUAL_IO : sfdr_pkg::OP_NONE;
      cnt_r <= '0;
      ones_r <= 1'b1;
    end else if (cs_rise) begin
      st_r <= sfdr_pkg::ST_IDLE;
    end else if (sclk_rise) begin
      cnt_r <= phase_end ? 5'h00 : 5'(cnt_r + sfdr_pkg::CNT_ONE);
      ones_r <= ones_r & pin_q.io0 & pin_q.io1;
      case (st_r)
        sfdr_pkg::ST_CMD: begin
          sh_r <= byte1;
          if (phase_end) begin
            cmd_r <= byte1;
            st_r <= cmd_next;
          end
        end
        sfdr_pkg::ST_ADDR1: begin
          addr_r <= addr1_nxt;
          if (phase_end) begin
            col_r <= addr1_nxt[7:0];
            st_r <= (cmd_r == sfdr_pkg::OP_PROG) ? sfdr_pkg::ST_PGM : sfdr_pkg::ST_DUMMY;
          end
        end
        sfdr_pkg::ST_ADDR2: begin
          addr_r <= addr2_nxt; // R4
          if (phase_end) begin
            st_r <= sfdr_pkg::ST_MODE;
          end
        end
        sfdr_pkg::ST_MODE: begin
          sh_r <= byte2; // R5
          if (phase_end) begin
            st_r <= esc_hit ? sfdr_pkg::ST_IDLE : sfdr_pkg::ST_RDOUT; // R9
          end
        end
        sfdr_pkg::ST_DUMMY: begin
          if (phase_end) begin
            st_r <= sfdr_pkg::ST_RDOUT; // R2
          end
        end
        sfdr_pkg::ST_PGM: begin
          sh_r <= byte1;
          if (phase_end) begin
            col_r <= 8'(col_r + 8'h01); // R14
          end
        end
        default: begin
        end
      endcase
    end else if (rd_load) begin
      addr_r <= sfdr_pkg::ADDR_W'(addr_r + 24'h000001); // R22
    end
  end

  // Mode byte persists across select; reserved bits are stored, never decoded
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_r <= sfdr_pkg::MODE_RESET;
    end else if (esc_hit) begin
      mode_r[sfdr_pkg::MODE_BIT_FOUR] <= 1'b1; // R9
    end else if (mode_end) begin
      mode_r <= byte2; // R6 R7 R8 R23
    end
  end

  // ================================================================
  // Page buffer, program cycle and array
  logic [7:0] pbuf [sfdr_pkg::PAGE_BYTES];
  logic [sfdr_pkg::PAGE_BYTES-1:0] mask_r;
  logic [7:0] mem [MEM_BYTES];
  logic [sfdr_pkg::TMR_W-1:0] tmr_r;
  logic [PG_W-1:0] pg_r;
  logic [PG_W-1:0] addr_pg;
  logic [2:0] prot_r;
  logic pgm_end;
  logic pgm_go;
  logic pgm_drop;
  logic prog_done;
  logic drop_r;
  logic drop_clr;

  function automatic logic prot_hit(input logic [2:0] bp, input logic [PG_W-1:0] pg);
    int n;
    n = MEM_PAGES >> (sfdr_pkg::PROT_TOP - bp);
    prot_hit = (bp != 3'h0) && (int'(pg) >= MEM_PAGES - n);
  endfunction

  assign addr_pg = addr_r[MEM_AW-1:sfdr_pkg::PAGE_AW];
  assign pgm_end = cs_rise & (st_r == sfdr_pkg::ST_PGM);
  assign pgm_go = pgm_end & (|mask_r) & (cnt_r == 5'h00) & wel_r
                  & ~prot_hit(prot_r, addr_pg); // R12 R15 R19
  assign pgm_drop = pgm_end & ~pgm_go;
  assign prog_done = busy_r & (tmr_r == sfdr_pkg::TMR_ONE);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_r <= 1'b0;
      wel_r <= 1'b0;
      tmr_r <= '0;
      pg_r <= '0;
    end else if (pgm_go) begin
      busy_r <= 1'b1; // R16
      tmr_r <= sfdr_pkg::TMR_W'(PROG_CYC);
      pg_r <= addr_pg;
    end else if (busy_r) begin
      tmr_r <= sfdr_pkg::TMR_W'(tmr_r - sfdr_pkg::TMR_ONE);
      if (prog_done) begin
        busy_r <= 1'b0; // R16
        wel_r <= 1'b0; // R18
      end
    end else if (wren_hit) begin
      wel_r <= 1'b1; // R20
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_r <= '0;
    end else if (cs_fall && !busy_r) begin
      mask_r <= '0;
    end else if (pgm_byte) begin
      mask_r[col_r] <= 1'b1; // R13
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (pgm_byte) begin
      pbuf[col_r] <= byte1; // R14
    end
  end

  // Programming only clears bits; bytes not flagged in mask_r are skipped, so unsent bytes are kept
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= sfdr_pkg::ERASED;
      end
    end else if (prog_done) begin
      for (int i = 0; i < sfdr_pkg::PAGE_BYTES; i++) begin
        if (mask_r[i]) begin
          mem[{pg_r, 8'(i)}] <= mem[{pg_r, 8'(i)}] & pbuf[i]; // R13
        end
      end
    end
  end

  // ================================================================
  // Lane drivers, updated on serial clock falling edges
  logic [7:0] ob_r;
  logic [7:0] rd_src;
  logic [7:0] st_src;
  logic [7:0] status_byte;

  assign status_byte = {3'h0, prot_r, wel_r, busy_r};
  assign rd_src = (out_cnt_r == 3'h0) ? mem[addr_r[MEM_AW-1:0]] : ob_r;
  assign st_src = (out_cnt_r == 3'h0) ? status_byte : ob_r;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      IO0_OUT <= 1'b0;
      IO1_OUT <= 1'b0;
      IO0_OE_B <= 1'b1;
      IO1_OE_B <= 1'b1;
      ob_r <= '0;
      out_cnt_r <= '0;
    end else if (cs_fall || cs_rise) begin
      IO0_OE_B <= 1'b1;
      IO1_OE_B <= 1'b1;
      out_cnt_r <= '0;
    end else if (sclk_fall && st_r == sfdr_pkg::ST_RDOUT) begin
      IO1_OUT <= rd_src[7]; // R21
      IO0_OUT <= rd_src[6]; // R21
      IO0_OE_B <= 1'b0; // R1 R3
      IO1_OE_B <= 1'b0; // R1
      ob_r <= {rd_src[5:0], 2'b00};
      out_cnt_r <= 3'(out_cnt_r + sfdr_pkg::OUT_STEP_DUAL);
    end else if (sclk_fall && st_r == sfdr_pkg::ST_STAT) begin
      IO1_OUT <= st_src[7]; // R17
      IO1_OE_B <= 1'b0;
      ob_r <= {st_src[6:0], 1'b0};
      out_cnt_r <= 3'(out_cnt_r + sfdr_pkg::OUT_STEP_SINGLE);
    end
  end

  // ================================================================
  // Register bus slave, one wait state per access
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] rd_word;

  assign acc = PSEL & PENABLE;
  assign hit_ctrl = (PADDR == sfdr_pkg::REG_CTRL);
  assign hit_stat = (PADDR == sfdr_pkg::REG_STATUS);
  assign drop_clr = acc & PREADY & PWRITE & hit_stat & PWDATA[sfdr_pkg::ST_DROP];
  assign rd_word = hit_ctrl ? {29'h0, prot_r} :
                   hit_stat ? {16'h0, mode_r, 4'h0, drop_r, cont_mode, wel_r, busy_r} : 32'h0;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= acc & ~PREADY;
      PRDATA <= (acc & ~PREADY & ~PWRITE) ? rd_word : 32'h0;
      PSLVERR <= acc & ~PREADY & ~(hit_ctrl | hit_stat);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prot_r <= 3'h0;
    end else if (acc && PREADY && PWRITE && hit_ctrl) begin
      prot_r <= PWDATA[2:0];
    end
  end

  // Sticky discard flag: a new discard wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      drop_r <= 1'b0;
    end else if (pgm_drop) begin
      drop_r <= 1'b1;
    end else if (drop_clr) begin
      drop_r <= 1'b0;
    end
  end

  // ================================================================
  // Checks
  AST_DUAL_DRIVE: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R1
    sclk_fall && st_r == sfdr_pkg::ST_RDOUT |=> !IO0_OE_B && !IO1_OE_B)
    else $error("dual read did not drive both lanes");
  AST_DUMMY_QUIET: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R2
    st_r == sfdr_pkg::ST_DUMMY |-> IO0_OE_B && IO1_OE_B)
    else $error("lane driven during dummy clocks");
  AST_MODE_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R6
    mode_end && !esc_hit && byte2[5:4] == sfdr_pkg::MODE_KEEP |=> cont_mode)
    else $error("mode pair 10 did not enter persistent mode");
  AST_SKIP_OPCODE: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R23
    cs_fall && cont_mode |=> st_r == sfdr_pkg::ST_ADDR2 && cmd_r == sfdr_pkg::OP_RD_DUAL_IO)
    else $error("persistent mode did not skip opcode");
  AST_MODE_EXIT: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R7
    mode_end && byte2[5:4] != sfdr_pkg::MODE_KEEP |=> !cont_mode)
    else $error("mode pair other than 10 kept persistent mode");
  AST_ESCAPE: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R9
    esc_hit |=> mode_r[sfdr_pkg::MODE_BIT_FOUR] && st_r == sfdr_pkg::ST_IDLE)
    else $error("all-ones escape failed");
  AST_WRAP: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R14
    pgm_byte |=> col_r == $past(col_r) + 8'h01)
    else $error("program column did not advance with wrap");
  AST_DISCARD: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R15
    pgm_end && cnt_r != 5'h00 |=> !busy_r && drop_r)
    else $error("partial byte did not discard program");
  AST_DONE: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R18
    prog_done |=> !busy_r && !wel_r)
    else $error("program end did not clear busy and latch");
  AST_BUSY_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R24
    cmd_end && busy_r && byte1 == sfdr_pkg::OP_RD_DUAL_IO |=> st_r == sfdr_pkg::ST_IDLE)
    else $error("read accepted while busy");
endmodule

// *** design/sfdr_pin_sync.sv ***
`timescale 1ns/1ps
// ==================================================================
// Three-stage pin synchroniser; a change counts once stages 2 and 3 agree
module sfdr_pin_sync (
  input logic clk,
  input logic rst_b,
  input sfdr_pkg::sfdr_pins_t pins_in,
  output sfdr_pkg::sfdr_pins_t pins_out
);
  sfdr_pkg::sfdr_pins_t s1_r;
  sfdr_pkg::sfdr_pins_t s2_r;
  sfdr_pkg::sfdr_pins_t s3_r;
  sfdr_pkg::sfdr_pins_t q_r;
  logic [$bits(sfdr_pkg::sfdr_pins_t)-1:0] agree;
  logic [$bits(sfdr_pkg::sfdr_pins_t)-1:0] q_nxt;

  assign agree = ~(s2_r ^ s3_r);
  assign q_nxt = (agree & s3_r) | (~agree & q_r);
  assign pins_out = q_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= sfdr_pkg::PINS_IDLE;
      s2_r <= sfdr_pkg::PINS_IDLE;
      s3_r <= sfdr_pkg::PINS_IDLE;
      q_r <= sfdr_pkg::PINS_IDLE;
    end else begin
      s1_r <= pins_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= sfdr_pkg::sfdr_pins_t'(q_nxt);
    end
  end
endmodule

// *** design/sfdr_pkg.sv ***
// ==================================================================
// Shared constants and types for the dual-lane flash sequencer
package sfdr_pkg;
  // ================================================================
  // Command codes
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RD_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_RD_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_NONE = 8'h00;

  // ================================================================
  // Phase lengths, last clock index of each phase
  localparam int ADDR_W = 24;
  localparam logic [4:0] ADDR1_LAST = 5'h17;
  localparam logic [4:0] ADDR2_LAST = 5'h0b;
  localparam logic [4:0] MODE_LAST = 5'h03;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [2:0] OUT_STEP_DUAL = 3'h2;
  localparam logic [2:0] OUT_STEP_SINGLE = 3'h1;

  // ================================================================
  // Read mode byte
  localparam logic [1:0] MODE_KEEP = 2'h2;
  localparam int MODE_BIT_FOUR = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // ================================================================
  // Array and protection
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_AW = 8;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [2:0] PROT_TOP = 3'h7;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;
  localparam int CLK_MHZ = 200;
  localparam int NS_PER_US = 1000;

  // ================================================================
  // Register bus map
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int ST_BUSY = 0;
  localparam int ST_WLATCH = 1;
  localparam int ST_CONT = 2;
  localparam int ST_DROP = 3;
  localparam int ST_MODE_LSB = 8;

  // ================================================================
  // Types
  typedef struct packed {
    logic cs_b;
    logic sclk;
    logic io1;
    logic io0;
  } sfdr_pins_t;

  localparam sfdr_pins_t PINS_IDLE = '{cs_b: 1'b1, sclk: 1'b0, io1: 1'b0, io0: 1'b0};

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_CMD   = 9'h002,
    ST_ADDR1 = 9'h004,
    ST_ADDR2 = 9'h008,
    ST_MODE  = 9'h010,
    ST_DUMMY = 9'h020,
    ST_RDOUT = 9'h040,
    ST_STAT  = 9'h080,
    ST_PGM   = 9'h100
  } sfdr_state_t;
endpackage

// *** sim/serial_flash_dual_read_program_tb.sv ***
`timescale 1ns/1ps
// ==================================================================
// Bench: APB and serial host against a byte-array flash model
module serial_flash_dual_read_program_tb;
  localparam logic [7:0] RS = sfdr_pkg::REG_STATUS;
  localparam logic [7:0] RC = sfdr_pkg::REG_CTRL;
  logic clk = 1'b0;
  logic rst_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, r;
  logic pready, pslverr, e;
  int oe_cnt = 0;
  int n0;
  wire cs_b, sclk, io0, io1, d0, oe0_b, d1, oe1_b;
  logic [7:0] mem [512];
  logic [7:0] lf = 8'h63;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  sfdr_core #(.PROG_TIME_NS(10000), .MEM_PAGES(2)) u_dut (
    .SYS_CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk),
    .IO0_IN(io0), .IO0_OUT(d0), .IO0_OE_B(oe0_b),
    .IO1_IN(io1), .IO1_OUT(d1), .IO1_OE_B(oe1_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  sfdr_host_mdl u_host (.clk(clk), .cs_b(cs_b), .sclk(sclk), .io0(io0), .io1(io1),
    .d0(d0), .oe0_b(oe0_b), .d1(d1), .oe1_b(oe1_b));
  // ================================================================
  // Checking and closing
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!oe0_b || !oe1_b) oe_cnt <= oe_cnt + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] ex(input int a, input int n);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < n; i++) v = {v[23:0], mem[(a + i) % 512]};
    return v;
  endfunction
  // ================================================================
  // Bus and link transfers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [7:0] c);
    u_host.sel(1'b1);
    u_host.sh(8, 1'b0, 1'b1, {24'h0, c}, r);
    u_host.sel(1'b0);
  endtask
  task automatic sst();
    u_host.sel(1'b1);
    u_host.sh(8, 1'b0, 1'b1, 32'h05, r);
    u_host.sh(8, 1'b0, 1'b1, 32'h0, r);
    u_host.sel(1'b0);
  endtask
  task automatic esc();
    u_host.sel(1'b1);
    u_host.sh(16, 1'b1, 1'b1, 32'hffffffff, r);
    u_host.sel(1'b0);
  endtask
  task automatic prg(input int a, input int n, input bit ok, input bit cut);
    int p;
    u_host.sel(1'b1);
    u_host.sh(8, 1'b0, 1'b1, 32'h02, r);
    u_host.sh(24, 1'b0, 1'b1, a, r);
    for (int i = 0; i < n; i++) begin
      lf = lfsr(lf);
      p = (a & 'h100) | ((a + i) & 'hff);
      if (ok) mem[p] = mem[p] & lf;
      u_host.sh(8, 1'b0, 1'b1, {24'h0, lf}, r);
    end
    if (cut) u_host.sh(4, 1'b0, 1'b1, 32'h0, r);
    u_host.sel(1'b0);
  endtask
  task automatic rd3(input int a, input int n);
    u_host.sel(1'b1);
    u_host.sh(8, 1'b0, 1'b1, 32'h3b, r);
    u_host.sh(24, 1'b0, 1'b1, a, r);
    u_host.sh(8, 1'b0, 1'b0, 32'h0, r);
    u_host.sh(4 * n, 1'b1, 1'b0, 32'h0, r);
    u_host.sel(1'b0);
  endtask
  task automatic rdb(input bit oc, input int a, input logic [7:0] m, input int n);
    u_host.sel(1'b1);
    if (oc) u_host.sh(8, 1'b0, 1'b1, 32'hbb, r);
    u_host.sh(16, 1'b1, 1'b1, {a[23:0], m}, r);
    u_host.sh(4 * n, 1'b1, 1'b0, 32'h0, r);
    u_host.sel(1'b0);
  endtask
  // ================================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hff;
    rst_b <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    esc();
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, RC, 32'h5);
    apb(1'b0, RC, 32'h0);
    chk(r, 32'h5);
    apb(1'b1, RC, 32'h0);
    apb(1'b0, RS, 32'h0);
    chk(r & 32'hf, 32'h0);
    prg(32'h40, 1, 1'b0, 1'b0);
    apb(1'b0, RS, 32'h0);
    chk(r & 32'hf, 32'h0);
    apb(1'b1, RS, 32'h8);
    op(8'h06);
    apb(1'b0, RS, 32'h0);
    chk(r & 32'hf, 32'h2);
    prg(32'hfe, 3, 1'b1, 1'b0);
    sst();
    chk(r & 32'hff, 32'h3);
    n0 = oe_cnt;
    rd3(32'hfe, 2);
    chk(oe_cnt - n0, 32'h0);
    do apb(1'b0, RS, 32'h0); while (r[0] !== 1'b0);
    chk(r & 32'h3, 32'h0);
    rd3(32'hfe, 3);
    chk(r, ex(32'hfe, 3));
    rdb(1'b1, 32'h0, 8'ha5, 2);
    chk(r, ex(32'h0, 2));
    apb(1'b0, RS, 32'h0);
    chk(r & 32'hff04, 32'ha504);
    rdb(1'b0, 32'hfe, 8'h4c, 1);
    chk(r, ex(32'hfe, 1));
    apb(1'b0, RS, 32'h0);
    chk(r & 32'h4, 32'h0);
    rdb(1'b1, 32'h100, 8'h20, 1);
    chk(r, ex(32'h100, 1));
    op(8'h06);
    apb(1'b0, RS, 32'h0);
    chk(r & 32'h6, 32'h4);
    esc();
    apb(1'b0, RS, 32'h0);
    chk(r & 32'h1004, 32'h1000);
    op(8'h06);
    sst();
    chk(r & 32'hff, 32'h2);
    prg(32'h40, 1, 1'b0, 1'b1);
    apb(1'b0, RS, 32'h0);
    chk(r & 32'h9, 32'h8);
    apb(1'b1, RS, 32'h8);
    apb(1'b1, RC, 32'h7);
    op(8'h06);
    prg(32'h40, 1, 1'b0, 1'b0);
    apb(1'b0, RS, 32'h0);
    chk(r & 32'h9, 32'h8);
    apb(1'b1, RC, 32'h0);
    rd3(32'h40, 1);
    chk(r, ex(32'h40, 1));
    end_sim();
  end
endmodule

// *** sim/sfdr_host_mdl.sv ***
`timescale 1ns/1ps
// ==================================================================
// Host end of the serial link: select, clock and two shared lanes
module sfdr_host_mdl (
  input wire logic clk,
  output logic cs_b,
  output logic sclk,
  output logic io0,
  output logic io1,
  input wire logic d0,
  input wire logic oe0_b,
  input wire logic d1,
  input wire logic oe1_b
);
  logic h0, h1, hoe_b, flt;
  // Undriven lanes show a changing pattern, not the last value
  assign io0 = !oe0_b ? d0 : !hoe_b ? h0 : flt;
  assign io1 = !oe1_b ? d1 : !hoe_b ? h1 : ~flt;
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    h0 = 1'b0;
    h1 = 1'b0;
    hoe_b = 1'b1;
    flt = 1'b0;
  end
  always #20 flt = ~flt;
  // Half a link clock is eight system clocks; pins change just after an edge
  task automatic sel(input bit on);
    repeat (8) @(posedge clk);
    cs_b <= !on;
    hoe_b <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // n clocks; two bits per clock when dual; drv low releases the lanes
  task automatic sh(input int n, input bit dual, input bit drv, input logic [31:0] v,
                    output logic [31:0] r);
    int k;
    r = '0;
    k = dual ? 2 * n : n;
    for (int i = 0; i < n; i++) begin
      hoe_b <= !drv;
      h1 <= dual ? v[k-1-2*i] : 1'b0;
      h0 <= dual ? v[k-2-2*i] : v[n-1-i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      r = dual ? {r[29:0], io1, io0} : {r[30:0], io1};
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask
endmodule
